// *** inc/addr_mode_pkg.sv ***
package addr_mode_pkg;

  // addressing modes chosen by the opcode decoder outside
  typedef enum logic [2:0]
  {
    MODE_INHERENT,
    MODE_IMMEDIATE,
    MODE_EXTENDED,
    MODE_DIRECT,
    MODE_INDEXED,
    MODE_BRANCH
  } addr_mode_t;

  // register-select codes in swap/copy postbytes
  localparam logic [3:0] SEL_ACC_D   = 4'h0;
  localparam logic [3:0] SEL_INDEX_X = 4'h1;
  localparam logic [3:0] SEL_INDEX_Y = 4'h2;
  localparam logic [3:0] SEL_STACK_U = 4'h3;
  localparam logic [3:0] SEL_STACK_S = 4'h4;
  localparam logic [3:0] SEL_PROG_CT = 4'h5;
  localparam logic [3:0] SEL_ACC_A   = 4'h8;
  localparam logic [3:0] SEL_ACC_B   = 4'h9;
  localparam logic [3:0] SEL_FLAGS   = 4'ha;
  localparam logic [3:0] SEL_PAGE    = 4'hb;

  // one-hot register ids, bit order of the push/restore mask
  localparam int REG_W = 10;
  localparam int BIT_FLAGS = 0;
  localparam int BIT_ACC_A = 1;
  localparam int BIT_ACC_B = 2;
  localparam int BIT_PAGE  = 3;
  localparam int BIT_IDX_X = 4;
  localparam int BIT_IDX_Y = 5;
  localparam int BIT_OTHER = 6;
  localparam int BIT_PC    = 7;
  localparam int BIT_ACC_D = 8;
  localparam int BIT_OWN_S = 9;

  // indexed postbyte low-four-bit types
  localparam logic [3:0] IX_INC1 = 4'h0;
  localparam logic [3:0] IX_INC2 = 4'h1;
  localparam logic [3:0] IX_DEC1 = 4'h2;
  localparam logic [3:0] IX_DEC2 = 4'h3;
  localparam logic [3:0] IX_NONE = 4'h4;
  localparam logic [3:0] IX_ACCB = 4'h5;
  localparam logic [3:0] IX_ACCA = 4'h6;
  localparam logic [3:0] IX_OFF8 = 4'h8;
  localparam logic [3:0] IX_OFF16 = 4'h9;
  localparam logic [3:0] IX_ACCD = 4'hb;
  localparam logic [3:0] IX_PC8  = 4'hc;
  localparam logic [3:0] IX_PC16 = 4'hd;
  localparam logic [3:0] IX_EXTI = 4'hf;
  localparam int IX_IND_BIT = 4;
  localparam logic [7:0] EXT_IND_POSTBYTE = 8'h9f;

  // pointer field codes
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_U = 2'h2;
  localparam logic [1:0] PTR_S = 2'h3;

endpackage

// *** hdl/reg_select_decode.sv ***
`timescale 1ns/1ps

// register-select decoding for swap/copy and push/restore postbytes
module reg_select_decode
  import addr_mode_pkg::*;
(
  input  wire logic [7:0]       postbyte_i,
  input  wire logic             use_user_i,
  output logic [REG_W-1:0]      swap_src_o,
  output logic [REG_W-1:0]      swap_dst_o,
  output logic                  swap_bad_o,
  output logic [REG_W-1:0]      stack_mask_o
);

  // nibble to one-hot; unknown codes set only the extra top bit
  function automatic logic [REG_W:0] nib_dec(input logic [3:0] c,
                                              input logic usr);
    logic [REG_W:0] r;
    r = '0;
    case (c)
      SEL_ACC_D:   r[BIT_ACC_D] = 1'b1;
      SEL_INDEX_X: r[BIT_IDX_X] = 1'b1;
      SEL_INDEX_Y: r[BIT_IDX_Y] = 1'b1;
      SEL_STACK_U: r[usr ? BIT_OWN_S : BIT_OTHER] = 1'b1;
      SEL_STACK_S: r[usr ? BIT_OTHER : BIT_OWN_S] = 1'b1;
      SEL_PROG_CT: r[BIT_PC] = 1'b1;
      SEL_ACC_A:   r[BIT_ACC_A] = 1'b1;
      SEL_ACC_B:   r[BIT_ACC_B] = 1'b1;
      SEL_FLAGS:   r[BIT_FLAGS] = 1'b1;
      SEL_PAGE:    r[BIT_PAGE] = 1'b1;
      default:     r[REG_W] = 1'b1;
    endcase
    return r;
  endfunction

  logic [REG_W:0] src_d;
  logic [REG_W:0] dst_d;

  // upper nibble source, lower destination
  always_comb
  begin
    src_d = nib_dec(postbyte_i[7:4], use_user_i);
    dst_d = nib_dec(postbyte_i[3:0], use_user_i);
    swap_src_o = src_d[REG_W-1:0];
    swap_dst_o = dst_d[REG_W-1:0];
    swap_bad_o = src_d[REG_W] | dst_d[REG_W];
    // bits 7..0 map straight onto the mask order
    stack_mask_o = {2'b00, postbyte_i};
  end

endmodule

// *** hdl/addr_mode_decoder.sv ***
`timescale 1ns/1ps

// Overview of operation
// - immediate operand is the one or two bytes after the opcode
// - swap/copy postbyte: upper nibble source, lower nibble destination
// - undefined swap/copy codes flagged, outcome otherwise unspecified
// - push/restore postbyte bit per register, program counter at bit 7
// - extended mode: two following bytes are the full address
// - direct mode: page base high byte, following byte low byte
// - constant offset added to pointer, pointer left unchanged
// - constant-offset postbyte decode; indirect 5-bit form becomes 8-bit
// - 5-bit offset in postbyte, longer offsets in following bytes
// - accumulator offset added signed, no register modified
// - auto-step decode; indirect allowed only for step-by-two
// - auto-increment uses old pointer then adds step
// - auto-decrement subtracts step then uses new pointer
// - program-counter relative with 8 or 16-bit signed offset
// - indirection reads two bytes at the formed effective address as final address
// - postbyte 9f reads final address via 16-bit pointer
// - taken branch loads program counter plus signed offset
// - short branch uses one signed offset byte
// - long branch uses two-byte signed offset
module addr_mode_decoder
  import addr_mode_pkg::*;
(
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     start_i,
  input  wire addr_mode_pkg::addr_mode_t mode_i,
  input  wire logic                     wide_i,
  input  wire logic                     cond_true_i,
  input  wire logic                     byte_valid_i,
  input  wire logic [7:0]               byte_i,
  input  wire logic                     mem_ready_i,
  input  wire logic [7:0]               mem_data_i,
  input  wire logic [15:0]              pc_i,
  input  wire logic [7:0]               page_i,
  input  wire logic [7:0]               acc_a_i,
  input  wire logic [7:0]               acc_b_i,
  input  wire logic [15:0]              idx_x_i,
  input  wire logic [15:0]              idx_y_i,
  input  wire logic [15:0]              stk_u_i,
  input  wire logic [15:0]              stk_s_i,
  input  wire logic                     use_user_i,
  output logic                          byte_ready_o,
  output logic                          mem_req_o,
  output logic [15:0]                   mem_addr_o,
  output logic                          done_o,
  output logic [15:0]                   ea_o,
  output logic [15:0]                   operand_o,
  output logic                          operand_valid_o,
  output logic                          ptr_we_o,
  output logic [1:0]                    ptr_sel_o,
  output logic [15:0]                   ptr_val_o,
  output logic                          pc_we_o,
  output logic [15:0]                   pc_val_o,
  output logic                          bad_postbyte_o,
  output logic [REG_W-1:0]              swap_src_o,
  output logic [REG_W-1:0]              swap_dst_o,
  output logic                          swap_bad_o,
  output logic [REG_W-1:0]              stack_mask_o
);

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_POST,
    ST_HI,
    ST_LO,
    ST_IND_HI,
    ST_IND_LO,
    ST_DONE
  } state_t;

  state_t      state_reg, state_next;
  addr_mode_t  mode_reg, mode_next;
  logic        wide_reg, wide_next;
  logic        cond_reg, cond_next;
  logic        ind_reg, ind_next;
  logic [7:0]  post_reg, post_next;
  logic [15:0] word_reg, word_next;
  logic [15:0] ea_reg, ea_next;
  logic [15:0] opnd_reg, opnd_next;
  logic        opv_reg, opv_next;
  logic        bad_reg, bad_next;
  logic        pwe_reg, pwe_next;
  logic [15:0] pval_reg, pval_next;
  logic        pcwe_reg, pcwe_next;
  logic [15:0] pcval_reg, pcval_next;
  logic        fin_reg, fin_next;

  // the postbyte register-select helper works on the latched postbyte
  reg_select_decode u_sel
  (
    .postbyte_i   (post_reg),
    .use_user_i   (use_user_i),
    .swap_src_o   (swap_src_o),
    .swap_dst_o   (swap_dst_o),
    .swap_bad_o   (swap_bad_o),
    .stack_mask_o (stack_mask_o)
  );

  // pointer selected by the two-bit field
  function automatic logic [15:0] ptr_of(input logic [1:0] f,
    input logic [15:0] x, input logic [15:0] y,
    input logic [15:0] u, input logic [15:0] s);
    case (f)
      PTR_X:   return x;
      PTR_Y:   return y;
      PTR_U:   return u;
      default: return s;
    endcase
  endfunction

  // how many offset bytes an indexed postbyte wants
  function automatic logic [1:0] ix_bytes(input logic [7:0] p);
    if (!p[7])
      return 2'd0;
    case (p[3:0])
      IX_OFF8, IX_PC8:           return 2'd1;
      IX_OFF16, IX_PC16, IX_EXTI: return 2'd2;
      default:                   return 2'd0;
    endcase
  endfunction

  logic [15:0] base_ptr;
  logic [15:0] sx8;
  logic [15:0] sx5;
  logic [15:0] ix_ea;
  logic [15:0] new_ptr;
  logic        ix_step;
  logic        ix_bad;

  // indexed address arithmetic on the latched postbyte and offset
  always_comb
  begin
    base_ptr = ptr_of(post_reg[6:5], idx_x_i, idx_y_i, stk_u_i, stk_s_i);
    sx8 = {{8{word_reg[7]}}, word_reg[7:0]};
    sx5 = {{11{post_reg[4]}}, post_reg[4:0]};
    ix_ea = base_ptr;
    new_ptr = base_ptr;
    ix_step = 1'b0;
    ix_bad = 1'b0;
    if (!post_reg[7])
      ix_ea = base_ptr + sx5;
    else
    begin
      case (post_reg[3:0])
        IX_NONE:  ix_ea = base_ptr;
        IX_OFF8:  ix_ea = base_ptr + sx8;
        IX_OFF16: ix_ea = base_ptr + word_reg;
        IX_ACCA:  ix_ea = base_ptr + {{8{acc_a_i[7]}}, acc_a_i};
        IX_ACCB:  ix_ea = base_ptr + {{8{acc_b_i[7]}}, acc_b_i};
        IX_ACCD:  ix_ea = base_ptr + {acc_a_i, acc_b_i};
        IX_INC1, IX_INC2:
        begin
          ix_ea = base_ptr;
          new_ptr = base_ptr + {14'h0, post_reg[0], ~post_reg[0]};
          ix_step = 1'b1;
          ix_bad = post_reg[IX_IND_BIT] & ~post_reg[0];
        end
        IX_DEC1, IX_DEC2:
        begin
          new_ptr = base_ptr - {14'h0, post_reg[0], ~post_reg[0]};
          ix_ea = new_ptr;
          ix_step = 1'b1;
          ix_bad = post_reg[IX_IND_BIT] & ~post_reg[0];
        end
        IX_PC8:   ix_ea = pc_i + sx8;
        IX_PC16:  ix_ea = pc_i + word_reg;
        IX_EXTI:
        begin
          ix_ea = word_reg;
          ix_bad = (post_reg != EXT_IND_POSTBYTE);
        end
        default:  ix_bad = 1'b1;
      endcase
    end
  end

  logic [15:0] done_ea;

  // address once all stream bytes are in, before any indirection
  always_comb
  begin
    case (mode_reg)
      MODE_EXTENDED: done_ea = word_reg;
      MODE_DIRECT:   done_ea = {page_i, word_reg[7:0]};
      MODE_INDEXED:  done_ea = ix_ea;
      MODE_BRANCH:   done_ea = wide_reg ? pc_i + word_reg : pc_i + sx8;
      default:       done_ea = 16'h0000;
    endcase
  end

  // fetch sequencing and result capture
  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    wide_next = wide_reg;
    cond_next = cond_reg;
    ind_next = ind_reg;
    post_next = post_reg;
    word_next = word_reg;
    ea_next = ea_reg;
    opnd_next = opnd_reg;
    opv_next = 1'b0;
    bad_next = bad_reg;
    pwe_next = 1'b0;
    pval_next = pval_reg;
    pcwe_next = 1'b0;
    pcval_next = pcval_reg;
    fin_next = fin_reg;
    case (state_reg)
      ST_IDLE:
        if (start_i)
        begin
          mode_next = mode_i;
          wide_next = wide_i;
          cond_next = cond_true_i;
          ind_next = 1'b0;
          bad_next = 1'b0;
          word_next = 16'h0000;
          fin_next = 1'b0;
          case (mode_i)
            MODE_INHERENT: state_next = ST_DONE;
            MODE_EXTENDED: state_next = ST_HI;
            MODE_INDEXED:  state_next = ST_POST;
            MODE_DIRECT:   state_next = ST_LO;
            // one byte after the opcode unless wide
            default: state_next = wide_i ? ST_HI : ST_LO;
          endcase
        end
      ST_POST:
        if (byte_valid_i)
        begin
          post_next = byte_i;
          // bit 4 only means indirect on the long forms
          ind_next = byte_i[7] & byte_i[IX_IND_BIT];
          case (ix_bytes(byte_i))
            2'd2:    state_next = ST_HI;
            2'd1:    state_next = ST_LO;
            default: state_next = ST_DONE;
          endcase
        end
      ST_HI:
        if (byte_valid_i)
        begin
          word_next = {byte_i, 8'h00};
          state_next = ST_LO;
        end
      ST_LO:
        if (byte_valid_i)
        begin
          word_next = {word_reg[15:8], byte_i};
          state_next = ST_DONE;
          // register-select postbytes arrive as immediate bytes
          if (mode_reg == MODE_IMMEDIATE)
            post_next = byte_i;
        end
      ST_IND_HI:
        if (mem_ready_i)
        begin
          opnd_next = {mem_data_i, 8'h00};
          state_next = ST_IND_LO;
        end
      ST_IND_LO:
        if (mem_ready_i)
        begin
          ea_next = {opnd_reg[15:8], mem_data_i};
          state_next = ST_IDLE;
        end
      ST_DONE:
      begin
        ea_next = done_ea;
        fin_next = 1'b1;
        state_next = ST_IDLE;
        if (mode_reg == MODE_IMMEDIATE)
        begin
          opnd_next = wide_reg ? word_reg : {8'h00, word_reg[7:0]};
          opv_next = 1'b1;
        end
        if (mode_reg == MODE_INDEXED)
        begin
          bad_next = ix_bad;
          pwe_next = ix_step;
          pval_next = new_ptr;
          if (ind_reg)
          begin
            state_next = ST_IND_HI;
            ea_next = done_ea;
          end
        end
        if (mode_reg == MODE_BRANCH && cond_reg)
        begin
          pcwe_next = 1'b1;
          pcval_next = done_ea;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg <= ST_IDLE;
      mode_reg <= MODE_INHERENT;
      wide_reg <= 1'b0;
      cond_reg <= 1'b0;
      ind_reg <= 1'b0;
      post_reg <= 8'h00;
      word_reg <= 16'h0000;
      ea_reg <= 16'h0000;
      opnd_reg <= 16'h0000;
      opv_reg <= 1'b0;
      bad_reg <= 1'b0;
      pwe_reg <= 1'b0;
      pval_reg <= 16'h0000;
      pcwe_reg <= 1'b0;
      pcval_reg <= 16'h0000;
      fin_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      wide_reg <= wide_next;
      cond_reg <= cond_next;
      ind_reg <= ind_next;
      post_reg <= post_next;
      word_reg <= word_next;
      ea_reg <= ea_next;
      opnd_reg <= opnd_next;
      opv_reg <= opv_next;
      bad_reg <= bad_next;
      pwe_reg <= pwe_next;
      pval_reg <= pval_next;
      pcwe_reg <= pcwe_next;
      pcval_reg <= pcval_next;
      fin_reg <= fin_next;
    end
  end

  // handshakes combinational, data from flops
  assign byte_ready_o = (state_reg == ST_POST) || (state_reg == ST_HI)
                        || (state_reg == ST_LO);
  assign mem_req_o = (state_reg == ST_IND_HI) || (state_reg == ST_IND_LO);
  assign mem_addr_o = (state_reg == ST_IND_LO) ? ea_reg + 16'h0001 : ea_reg;
  // low after reset until a decode, inherent ones included
  assign done_o = (state_reg == ST_IDLE) && fin_reg && !start_i;
  assign ea_o = ea_reg;
  assign operand_o = opnd_reg;
  assign operand_valid_o = opv_reg;
  assign ptr_we_o = pwe_reg;
  assign ptr_sel_o = post_reg[6:5];
  assign ptr_val_o = pval_reg;
  assign pc_we_o = pcwe_reg;
  assign pc_val_o = pcval_reg;
  assign bad_postbyte_o = bad_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence ind_lo_s;
    state_reg == ST_IND_LO && mem_ready_i;
  endsequence

  immediate_width_a: assert property (opv_reg && !wide_reg |->
    operand_o[15:8] == 8'h00) else $error("narrow operand high");
  extended_addr_a: assert property (state_reg == ST_DONE &&
    mode_reg == MODE_EXTENDED |=> ea_o == $past(word_reg))
    else $error("extended ea wrong");
  direct_page_a: assert property (state_reg == ST_DONE &&
    mode_reg == MODE_DIRECT |=> ea_o[7:0] == $past(word_reg[7:0]))
    else $error("direct low byte wrong");
  postinc_use_a: assert property (state_reg == ST_DONE &&
    mode_reg == MODE_INDEXED && post_reg[7] && post_reg[3:1] == 3'b000
    |=> ptr_we_o && ea_o != ptr_val_o) else $error("postinc order");
  predec_use_a: assert property (state_reg == ST_DONE &&
    mode_reg == MODE_INDEXED && !ind_reg && post_reg[7]
    && post_reg[3:1] == 3'b001 |=> ea_o == ptr_val_o)
    else $error("predec order");
  indirect_read_a: assert property (ind_lo_s |=>
    ea_o == {$past(opnd_reg[15:8]), $past(mem_data_i)})
    else $error("indirect ea wrong");
  branch_taken_a: assert property (state_reg == ST_DONE &&
    mode_reg == MODE_BRANCH |=> pc_we_o == $past(cond_reg))
    else $error("branch load wrong");
  const_no_write_a: assert property (state_reg == ST_DONE &&
    mode_reg == MODE_INDEXED && !post_reg[7] |=> !ptr_we_o)
    else $error("pointer written");
  step_bad_a: assert property (state_reg == ST_DONE && post_reg[7] &&
    mode_reg == MODE_INDEXED && post_reg[4:0] == 5'h10 |=> bad_postbyte_o)
    else $error("illegal indirect step");

endmodule

// *** sim/fetch_mem_model.sv ***
`timescale 1ns/1ps

// stands in for the fetch unit and the indirection memory sequencer
module fetch_mem_model
(
  input  wire logic        sys_clk_i,
  input  wire logic        load_i,
  input  wire logic [31:0] stream_i,
  input  wire logic [2:0]  count_i,
  input  wire logic [3:0]  slow_i,
  input  wire logic        byte_ready_i,
  input  wire logic        mem_req_i,
  input  wire logic [15:0] mem_addr_i,
  output logic             byte_valid_o = 1'b0,
  output logic [7:0]       byte_o = 8'h00,
  output logic             mem_ready_o = 1'b0,
  output logic [7:0]       mem_data_o = 8'h00
);
  int idx = 0;
  int wait_cnt = 0;

  // stream bytes held until taken; idle line toggles so stale data shows
  always @(posedge sys_clk_i)
  begin
    if (load_i)
      idx = 0;
    else if (byte_valid_o && byte_ready_i)
      idx = idx + 1;
    byte_valid_o <= (idx < count_i);
    byte_o <= (idx < count_i) ? stream_i[31-8*idx -: 8] : ~byte_o;
  end

  // memory answers after slow_i extra cycles, data derived from address
  always @(posedge sys_clk_i)
  begin
    if (mem_ready_o && mem_req_i)
    begin
      mem_ready_o <= 1'b0;
      wait_cnt = 0;
      mem_data_o <= ~mem_data_o;
    end
    else if (mem_req_i && !mem_ready_o && wait_cnt >= slow_i)
    begin
      mem_ready_o <= 1'b1;
      mem_data_o <= mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h3c;
    end
    else
    begin
      if (mem_req_i)
        wait_cnt = wait_cnt + 1;
      mem_data_o <= ~mem_data_o;
    end
  end
endmodule

// *** sim/eight_bit_cpu_address_mode_decoder_tb_top.sv ***
`timescale 1ns/1ps

`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
  n_errors++; end end

module eight_bit_cpu_address_mode_decoder_tb_top;
  import addr_mode_pkg::*;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, start_i = 1'b0;
  logic wide_i = 1'b0, cond_true_i = 1'b0, use_user_i = 1'b0;
  addr_mode_t mode_i = MODE_INHERENT;
  logic byte_valid_i, mem_ready_i, load = 1'b0;
  logic [7:0] byte_i, mem_data_i;
  logic [7:0] page_i = 8'h12, acc_a_i = 8'hf0, acc_b_i = 8'h05;
  logic [15:0] pc_i = 16'h4000, idx_x_i = 16'h1000, idx_y_i = 16'h2000;
  logic [15:0] stk_u_i = 16'h3000, stk_s_i = 16'h8000;
  logic [31:0] stream = 32'h0;
  logic [2:0] count = 3'h0;
  logic [3:0] slow = 4'h0;
  logic byte_ready_o, mem_req_o, done_o, operand_valid_o, ptr_we_o;
  logic pc_we_o, bad_postbyte_o, swap_bad_o;
  logic [15:0] mem_addr_o, ea_o, operand_o, ptr_val_o, pc_val_o;
  logic [1:0] ptr_sel_o;
  logic [REG_W-1:0] swap_src_o, swap_dst_o, stack_mask_o;
  logic seen_op, seen_ptr, seen_pc;
  logic [15:0] got_ptr, got_pc;
  logic [1:0] got_sel;
  int n_errors = 0;
  int n_checks = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  addr_mode_decoder dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .start_i(start_i), .mode_i(mode_i), .wide_i(wide_i),
    .cond_true_i(cond_true_i), .byte_valid_i(byte_valid_i),
    .byte_i(byte_i), .mem_ready_i(mem_ready_i), .mem_data_i(mem_data_i),
    .pc_i(pc_i), .page_i(page_i), .acc_a_i(acc_a_i), .acc_b_i(acc_b_i),
    .idx_x_i(idx_x_i), .idx_y_i(idx_y_i), .stk_u_i(stk_u_i),
    .stk_s_i(stk_s_i), .use_user_i(use_user_i),
    .byte_ready_o(byte_ready_o), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .done_o(done_o), .ea_o(ea_o),
    .operand_o(operand_o), .operand_valid_o(operand_valid_o),
    .ptr_we_o(ptr_we_o), .ptr_sel_o(ptr_sel_o), .ptr_val_o(ptr_val_o),
    .pc_we_o(pc_we_o), .pc_val_o(pc_val_o),
    .bad_postbyte_o(bad_postbyte_o), .swap_src_o(swap_src_o),
    .swap_dst_o(swap_dst_o), .swap_bad_o(swap_bad_o),
    .stack_mask_o(stack_mask_o));

  fetch_mem_model pm (.sys_clk_i(sys_clk_i), .load_i(load),
    .stream_i(stream), .count_i(count), .slow_i(slow),
    .byte_ready_i(byte_ready_o), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .byte_valid_o(byte_valid_i),
    .byte_o(byte_i), .mem_ready_o(mem_ready_i), .mem_data_o(mem_data_i));

  // one-cycle pulses are caught here, cleared when a decode starts
  always @(posedge sys_clk_i)
  begin
    seen_op <= (start_i !== 1'b1) && (seen_op || operand_valid_o === 1'b1);
    seen_ptr <= (start_i !== 1'b1) && (seen_ptr || ptr_we_o === 1'b1);
    seen_pc <= (start_i !== 1'b1) && (seen_pc || pc_we_o === 1'b1);
    if (ptr_we_o === 1'b1)
    begin
      got_ptr <= ptr_val_o;
      got_sel <= ptr_sel_o;
    end
    if (pc_we_o === 1'b1)
      got_pc <= pc_val_o;
  end

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one full decode: load the stream, pulse start, wait for done_o
  task automatic run(input addr_mode_t m, input logic w, input logic c,
                     input logic [31:0] bs, input logic [2:0] n,
                     input logic [3:0] sl);
    int k;
    @(posedge sys_clk_i);
    mode_i <= m;
    wide_i <= w;
    cond_true_i <= c;
    stream <= bs;
    count <= n;
    slow <= sl;
    load <= 1'b1;
    @(posedge sys_clk_i);
    load <= 1'b0;
    start_i <= 1'b1;
    @(posedge sys_clk_i);
    start_i <= 1'b0;
    for (k = 0; k < 60; k++)
    begin
      @(posedge sys_clk_i);
      #1;
      if (done_o === 1'b1)
        break;
    end
    `CHK("done", 1'b1, done_o)
    @(posedge sys_clk_i);
    #1;
  endtask

  // indexed form that must leave the pointer alone
  task automatic ix(input logic [31:0] bs, input logic [2:0] n,
                    input logic [15:0] ex);
    run(MODE_INDEXED, 1'b0, 1'b0, bs, n, 4'h0);
    `CHK("ix ea", ex, ea_o)
    `CHK("ix ptr we", 1'b0, seen_ptr)
  endtask

  task automatic t_simple;
    run(MODE_IMMEDIATE, 1'b0, 1'b0, 32'ha5000000, 3'h1, 4'h0);
    `CHK("imm8", 8'ha5, operand_o[7:0])
    `CHK("imm8 valid", 1'b1, seen_op)
    run(MODE_IMMEDIATE, 1'b1, 1'b0, 32'h80040000, 3'h2, 4'h0);
    `CHK("imm16", 16'h8004, operand_o)
    run(MODE_EXTENDED, 1'b0, 1'b0, 32'hcafe0000, 3'h2, 4'h0);
    `CHK("extended", 16'hcafe, ea_o)
    run(MODE_DIRECT, 1'b0, 1'b0, 32'h34000000, 3'h1, 4'h0);
    `CHK("direct", 16'h1234, ea_o)
    run(MODE_INHERENT, 1'b0, 1'b0, 32'h0, 3'h0, 4'h0);
    `CHK("inherent op", 1'b0, seen_op)
    $display("test simple finished");
  endtask

  task automatic t_offsets;
    ix(32'ha4000000, 3'h1, 16'h2000);
    ix(32'h50000000, 3'h1, 16'h2ff0);
    ix(32'he8800000, 3'h2, 16'h7f80);
    ix(32'h89123400, 3'h3, 16'h2234);
    ix(32'h86000000, 3'h1, 16'h0ff0);
    ix(32'h85000000, 3'h1, 16'h1005);
    ix(32'h8b000000, 3'h1, 16'h0005);
    ix(32'h8cfe0000, 3'h2, 16'h3ffe);
    ix(32'hed800000, 3'h3, 16'hc000);
    $display("test offsets finished");
  endtask

  task automatic t_auto;
    logic [7:0] pb [4] = '{8'h80, 8'ha1, 8'hc2, 8'he3};
    logic [15:0] ea [4] = '{16'h1000, 16'h2000, 16'h2fff, 16'h7ffe};
    logic [15:0] pv [4] = '{16'h1001, 16'h2002, 16'h2fff, 16'h7ffe};
    for (int i = 0; i < 4; i++)
    begin
      run(MODE_INDEXED, 1'b0, 1'b0, {pb[i], 24'h0}, 3'h1, 4'h0);
      `CHK("auto ea", ea[i], ea_o)
      `CHK("auto we", 1'b1, seen_ptr)
      `CHK("auto val", pv[i], got_ptr)
      `CHK("auto sel", 2'(i), got_sel)
    end
    run(MODE_INDEXED, 1'b0, 1'b0, 32'h90000000, 3'h1, 4'h0);
    `CHK("inc1 indirect", 1'b1, bad_postbyte_o)
    $display("test auto finished");
  endtask

  task automatic t_indirect;
    run(MODE_INDEXED, 1'b0, 1'b0, 32'h99001000, 3'h3, 4'h3);
    `CHK("ind", {mem_byte(16'h1010), mem_byte(16'h1011)}, ea_o)
    run(MODE_INDEXED, 1'b0, 1'b0, 32'h9fabcd00, 3'h3, 4'h0);
    `CHK("ext ind", {mem_byte(16'habcd), mem_byte(16'habce)}, ea_o)
    $display("test indirect finished");
  endtask

  task automatic t_branch;
    run(MODE_BRANCH, 1'b0, 1'b1, 32'h80000000, 3'h1, 4'h0);
    `CHK("short we", 1'b1, seen_pc)
    `CHK("short pc", 16'h3f80, got_pc)
    run(MODE_BRANCH, 1'b0, 1'b0, 32'h7f000000, 3'h1, 4'h0);
    `CHK("not taken", 1'b0, seen_pc)
    run(MODE_BRANCH, 1'b1, 1'b1, 32'h7fff0000, 3'h2, 4'h0);
    `CHK("long pc", 16'hbfff, got_pc)
    $display("test branch finished");
  endtask

  task automatic t_regsel;
    logic [3:0] cd [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8,
                            4'h9, 4'ha, 4'hb};
    int id [10] = '{BIT_ACC_D, BIT_IDX_X, BIT_IDX_Y, BIT_OTHER, BIT_OWN_S,
                    BIT_PC, BIT_ACC_A, BIT_ACC_B, BIT_FLAGS, BIT_PAGE};
    for (int i = 0; i < 10; i++)
    begin
      run(MODE_IMMEDIATE, 1'b0, 1'b0, {cd[i], cd[(i+3)%10], 24'h0},
          3'h1, 4'h0);
      `CHK("src", REG_W'(1) << id[i], swap_src_o)
      `CHK("dst", REG_W'(1) << id[(i+3)%10], swap_dst_o)
      `CHK("mask", {2'b00, cd[i], cd[(i+3)%10]}, stack_mask_o)
    end
    run(MODE_IMMEDIATE, 1'b0, 1'b0, 32'h6c000000, 3'h1, 4'h0);
    `CHK("bad code", 1'b1, swap_bad_o)
    use_user_i <= 1'b1;
    run(MODE_IMMEDIATE, 1'b0, 1'b0, 32'h34000000, 3'h1, 4'h0);
    `CHK("user src", REG_W'(1) << BIT_OWN_S, swap_src_o)
    `CHK("user dst", REG_W'(1) << BIT_OTHER, swap_dst_o)
    use_user_i <= 1'b0;
    $display("test regsel finished");
  endtask

  // watchdog well past the few hundred cycles the tests need
  initial
  begin
    #400000;
    n_errors++;
    summarize();
  end

  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_simple();
    t_offsets();
    t_auto();
    t_indirect();
    t_branch();
    t_regsel();
    summarize();
  end
endmodule
